// >>> core/power_fault_reset_control.sv
`default_nettype none
module power_fault_reset_control
  import pwr_seq_pkg::*;
#(
  parameter int RESET_TIMER_TICKS = RESET_TICKS,
  parameter int DIV               = XTAL_DIV
)(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // Pins and supply comparators
  input  wire logic        reset_pin,
  input  wire logic        test_pin,
  input  wire logic        debug_reset_n,
  input  wire logic        debug_enable_pin,
  input  wire logic        analog_supply_cmp,
  input  wire logic        system_supply_cmp,
  input  wire logic        core_supply_hi_cmp,
  input  wire logic        core_supply_lo_cmp,
  // Same-clock events
  input  wire logic        dog_overflow,
  input  wire logic        wake_event,
  // Special function register port
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_rd,
  output logic      [7:0]  sfr_rdata,
  // I/O register port
  input  wire logic [15:0] io_addr,
  input  wire logic        io_wr,
  input  wire logic [7:0]  io_wdata,
  input  wire logic        io_rd,
  output logic      [7:0]  io_rdata,
  // Supply status
  output logic      [2:0]  power_status_code,
  output logic             analog_supply_ok_flag,
  output logic             system_supply_ok_flag,
  output power_ctl_t       ctl,
  output logic             battery_irq,
  // Resets and boot
  output logic             cpu_core_reset,
  output logic             test_mux_reset,
  output logic             rtc_reset,
  output logic      [15:0] boot_addr,
  output logic             wake,
  // Watchdog and flags
  output logic             dog_enable,
  output logic             dog_restart,
  output logic             low_battery_wake_flag,
  output logic             dog_overflow_flag
);

  localparam int RCW = $clog2(RESET_MIN_CYC + 1);

  pins_t pins;
  logic  tick;

  pin_sync #(
    .WIDTH (8),
    .INIT  (PINS_RESET)
  ) u_sync (
    .core_clk (core_clk),
    .nrst     (nrst),
    .raw      ({reset_pin, test_pin, debug_reset_n, debug_enable_pin,
                analog_supply_cmp, system_supply_cmp, core_supply_hi_cmp,
                core_supply_lo_cmp}),
    .clean    (pins)
  );

  tick_divider #(
    .DIV (DIV)
  ) u_tick (
    .core_clk (core_clk),
    .nrst     (nrst),
    .tick     (tick)
  );

  // Register decode.
  logic wr_clock;
  logic wr_mode;
  logic wr_dog;
  logic soft_reset;
  logic mode_write;

  assign wr_clock   = io_wr && (io_addr == IO_CLOCK_CTRL);
  assign wr_mode    = io_wr && (io_addr == IO_MODE_CTRL);
  assign wr_dog     = io_wr && (io_addr == IO_DOG_CTRL);
  assign soft_reset = wr_clock && io_wdata[SOFT_RESET_BIT];
  assign mode_write = wr_mode && (io_wdata[SLEEP_BIT] || io_wdata[LCD_ONLY_BIT]);

  // Status code from the comparators.
  power_code_t code;

  always_comb
  begin
    if (pins.system_ok)
      code = pins.analog_ok ? PS_SYS_OK : PS_SYS_LOW;
    else if (!pins.core_ok_lo)
      code = PS_BAT_LOW;
    else if (!pins.core_ok_hi)
      code = PS_BAT_WEAK;
    else
      code = PS_BAT_OK;
  end

  // Reset pin qualification: a glitch shorter than the minimum never resets the chip.
  logic [RCW-1:0] rpin_cnt_q;
  logic [RCW-1:0] rpin_cnt_d;
  logic           pin_reset;

  always_comb
  begin
    rpin_cnt_d = '0;
    if (pins.reset_pin)
      rpin_cnt_d = (rpin_cnt_q == RCW'(RESET_MIN_CYC)) ? rpin_cnt_q : rpin_cnt_q + 1'b1;
  end

  assign pin_reset = (rpin_cnt_q == RCW'(RESET_MIN_CYC));

  // Sequencer.
  seq_state_t         state_q, state_d;
  logic [TIMER_W-1:0] timer_q, timer_d;
  logic [1:0]         mode_q, mode_d;
  logic               wake_q, wake_d;
  logic               lowbat_q, lowbat_d;
  logic               dogf_q, dogf_d;
  logic               wake_rise;
  logic               chip_reset;

  assign chip_reset = pin_reset || soft_reset;

  always_comb
  begin
    state_d  = state_q;
    timer_d  = timer_q;
    mode_d   = mode_q;
    wake_d   = wake_q;
    lowbat_d = lowbat_q;
    if (wr_mode)
      mode_d = {io_wdata[SLEEP_BIT], io_wdata[LCD_ONLY_BIT]};
    unique case (state_q)
      ST_PIN_RESET:
      begin
        wake_d = 1'b0;
        if (!pin_reset)
        begin
          state_d = ST_TIMER;
          timer_d = pins.system_ok ? TIMER_W'(RESET_TIMER_TICKS)
                                   : TIMER_W'(BATT_RESET_TICKS);
        end
      end
      ST_TIMER:
      begin
        if (tick)
        begin
          timer_d = timer_q - 1'b1;
          if (timer_q <= TIMER_W'(1))
          begin
            state_d = ST_RUN;
            wake_d  = 1'b1;
          end
        end
      end
      ST_RUN:
      begin
        if (mode_write)
        begin
          state_d = ST_DORMANT;
          wake_d  = 1'b0;
        end
        else if (!pins.system_ok && code == PS_BAT_LOW && !mode_q[1])
        begin
          state_d = ST_LOWBAT;
          timer_d = TIMER_W'(LOWBAT_TICKS);
        end
      end
      ST_LOWBAT:
      begin
        if (mode_write)
        begin
          state_d = ST_DORMANT;
          wake_d  = 1'b0;
        end
        else if (pins.system_ok || pins.core_ok_lo)
          state_d = ST_RUN;
        else if (tick)
        begin
          timer_d = timer_q - 1'b1;
          if (timer_q <= TIMER_W'(1))
          begin
            state_d = ST_HOLD;
            wake_d  = 1'b0;
          end
        end
      end
      ST_HOLD:
      begin
        if (pins.system_ok || pins.core_ok_lo)
        begin
          state_d  = ST_RUN;
          wake_d   = 1'b1;
          lowbat_d = 1'b1;
        end
      end
      ST_DORMANT:
      begin
        if (wake_event || pins.system_ok)
        begin
          mode_d = MODE_RESET;
          if (!pins.system_ok && !pins.core_ok_lo)
            state_d = ST_HOLD;
          else
          begin
            state_d = ST_RUN;
            wake_d  = 1'b1;
          end
        end
      end
      default:
        state_d = ST_PIN_RESET;
    endcase
    if (soft_reset)
    begin
      state_d = ST_TIMER;
      timer_d = TIMER_W'(SOFT_RESET_TICKS);
      mode_d  = MODE_RESET;
      wake_d  = 1'b0;
    end
    if (pin_reset)
    begin
      state_d = ST_PIN_RESET;
      mode_d  = MODE_RESET;
      wake_d  = 1'b0;
    end
    // A falling wake clears the flags; an overflow in the same cycle still wins.
    if (wake_q && !wake_d)
      lowbat_d = 1'b0;
    dogf_d = dogf_q;
    if ((wake_q && !wake_d) || pin_reset)
      dogf_d = 1'b0;
    if (dog_overflow)
      dogf_d = 1'b1;
  end

  assign wake_rise = !wake_q && wake_d;

  // Output registers.
  power_ctl_t  ctl_d, ctl_q;
  logic [2:0]  code_q;
  logic        aok_q, sok_q;
  logic        irq_q, irq_d;
  logic        restart_q, restart_d;
  logic [7:0]  sfr_q, sfr_d;
  logic [7:0]  io_q, io_d;

  always_comb
  begin
    ctl_d.cpu_reset         = !(state_d == ST_RUN || state_d == ST_LOWBAT);
    ctl_d.chip_reset        = chip_reset;
    ctl_d.on_battery        = !pins.system_ok;
    ctl_d.battery_run_mode  = !pins.system_ok && state_d != ST_DORMANT;
    ctl_d.flash_write_block = !pins.system_ok && code != PS_BAT_OK;
    // Converter enables live elsewhere; only the clocks are gated here.
    ctl_d.converter_clk_en  = pins.system_ok;
    irq_d     = !pins.system_ok && !ctl_q.on_battery;
    restart_d = (wr_dog && io_wdata[DOG_KICK_BIT])
                || (state_q == ST_DORMANT && wake_rise) || pins.debug_enable_pin;
    sfr_d = sfr_q;
    if (sfr_rd)
      sfr_d = (sfr_addr == SFR_POWER_STATUS) ? {5'h00, code_q} : 8'h00;
    io_d = io_q;
    if (io_rd)
    begin
      unique case (io_addr)
        IO_WAKE_FLAGS:
          io_d = (8'(lowbat_q) << LOWBAT_FLAG_BIT) | (8'(dogf_q) << DOG_FLAG_BIT);
        IO_MODE_CTRL:
          io_d = 8'(({7'h00, mode_q[1]} << SLEEP_BIT) | ({7'h00, mode_q[0]} << LCD_ONLY_BIT));
        default:
          io_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rpin_cnt_q <= '0;
      state_q    <= ST_PIN_RESET;
      timer_q    <= '0;
      mode_q     <= MODE_RESET;
      wake_q     <= 1'b0;
      lowbat_q   <= 1'b0;
      dogf_q     <= 1'b0;
      ctl_q      <= CTL_RESET;
      code_q     <= 3'h0;
      aok_q      <= 1'b0;
      sok_q      <= 1'b0;
      irq_q      <= 1'b0;
      restart_q  <= 1'b0;
      sfr_q      <= 8'h00;
      io_q       <= 8'h00;
    end
    else
    begin
      rpin_cnt_q <= rpin_cnt_d;
      state_q    <= state_d;
      timer_q    <= timer_d;
      mode_q     <= mode_d;
      wake_q     <= wake_d;
      lowbat_q   <= lowbat_d;
      dogf_q     <= dogf_d;
      ctl_q      <= ctl_d;
      code_q     <= code;
      aok_q      <= pins.analog_ok;
      sok_q      <= pins.system_ok;
      irq_q      <= irq_d;
      restart_q  <= restart_d;
      sfr_q      <= sfr_d;
      io_q       <= io_d;
    end
  end

  assign power_status_code     = code_q;
  assign analog_supply_ok_flag = aok_q;
  assign system_supply_ok_flag = sok_q;
  assign ctl                   = ctl_q;
  assign battery_irq           = irq_q;
  assign sfr_rdata             = sfr_q;
  assign io_rdata              = io_q;
  assign wake                  = wake_q;
  assign low_battery_wake_flag = lowbat_q;
  assign dog_overflow_flag     = dogf_q;
  assign dog_restart           = restart_q;
  // The core reset combines the sequencer reset with the debug pin; the debug pin never starts the timer.
  assign cpu_core_reset        = ctl_q.cpu_reset || !pins.debug_reset_n;
  assign test_mux_reset        = pin_reset && pins.test_pin;
  assign rtc_reset             = pin_reset && pins.test_pin;
  assign dog_enable            = !pins.debug_enable_pin;
  assign boot_addr             = BOOT_ADDR;

endmodule
`default_nettype wire

// >>> core/pwr_seq_pkg.sv
`default_nettype none
package pwr_seq_pkg;

  // Clock and crystal tick rates.
  localparam int CLK_HZ        = 40_000_000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int XTAL_HZ       = 32_768;
  localparam int XTAL_DIV      = CLK_HZ / XTAL_HZ;

  // Reset pin must stay high this long before the reset is trusted.
  localparam int RESET_MIN_NS  = 2000;
  localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Reset timer lengths and the low supply grace period, in crystal ticks.
  localparam int TIMER_W          = 13;
  localparam int RESET_TICKS      = 4100;
  localparam int BATT_RESET_TICKS = 2;
  localparam int SOFT_RESET_TICKS = 8;
  localparam int LOWBAT_TICKS     = 4;

  localparam logic [15:0] BOOT_ADDR = 16'h0000;

  // Register addresses and bit positions.
  localparam logic [7:0]  SFR_POWER_STATUS = 8'hF9;
  localparam logic [15:0] IO_CLOCK_CTRL    = 16'h2200;
  localparam logic [15:0] IO_WAKE_FLAGS    = 16'h28B0;
  localparam logic [15:0] IO_MODE_CTRL     = 16'h28B2;
  localparam logic [15:0] IO_DOG_CTRL      = 16'h28B4;
  localparam int SOFT_RESET_BIT  = 3;
  localparam int LOWBAT_FLAG_BIT = 2;
  localparam int DOG_FLAG_BIT    = 4;
  localparam int SLEEP_BIT       = 7;
  localparam int LCD_ONLY_BIT    = 6;
  localparam int DOG_KICK_BIT    = 7;
  localparam logic [1:0] MODE_RESET = 2'h0;

  typedef enum logic [2:0] {
    PS_SYS_OK   = 3'h0,
    PS_SYS_LOW  = 3'h1,
    PS_BAT_OK   = 3'h2,
    PS_BAT_WEAK = 3'h3,
    PS_BAT_LOW  = 3'h5
  } power_code_t;

  typedef enum logic [2:0] {
    ST_PIN_RESET = 3'h0,
    ST_TIMER     = 3'h1,
    ST_RUN       = 3'h2,
    ST_LOWBAT    = 3'h3,
    ST_HOLD      = 3'h4,
    ST_DORMANT   = 3'h5
  } seq_state_t;

  // Pins from outside the clock domain.
  typedef struct packed {
    logic reset_pin;
    logic test_pin;
    logic debug_reset_n;
    logic debug_enable_pin;
    logic analog_ok;
    logic system_ok;
    logic core_ok_hi;
    logic core_ok_lo;
  } pins_t;
  // Idle levels: supplies good and debug reset released, so no false battery edge follows reset.
  localparam logic [7:0] PINS_RESET = 8'h2F;

  // Power control outputs.
  typedef struct packed {
    logic cpu_reset;
    logic chip_reset;
    logic on_battery;
    logic battery_run_mode;
    logic flash_write_block;
    logic converter_clk_en;
  } power_ctl_t;
  localparam logic [5:0] CTL_RESET = 6'h31;

endpackage
`default_nettype wire

// >>> core/pin_sync.sv
`default_nettype none
module pin_sync
  import pwr_seq_pkg::*;
#(
  parameter int         WIDTH = 8,
  parameter logic [7:0] INIT  = PINS_RESET
)(
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             nrst,
  // Raw and filtered levels
  input  wire logic [WIDTH-1:0] raw,
  output logic      [WIDTH-1:0] clean
);

  for (genvar i = 0; i < WIDTH; i++)
  begin : g_bit
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic out_q;
    logic out_d;

    // The first stage feeds only the second; the output moves once stages two and three agree.
    always_comb
    begin
      out_d = out_q;
      if (s2_q == s3_q)
        out_d = s3_q;
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
      if (!nrst)
      begin
        s1_q  <= INIT[i];
        s2_q  <= INIT[i];
        s3_q  <= INIT[i];
        out_q <= INIT[i];
      end
      else
      begin
        s1_q  <= raw[i];
        s2_q  <= s1_q;
        s3_q  <= s2_q;
        out_q <= out_d;
      end
    end

    assign clean[i] = out_q;
  end

endmodule
`default_nettype wire

// >>> core/tick_divider.sv
`default_nettype none
module tick_divider
  import pwr_seq_pkg::*;
#(
  parameter int DIV = XTAL_DIV
)(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic nrst,
  // One-cycle crystal tick
  output logic      tick
);

  localparam int CW = $clog2(DIV);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          tick_q;
  logic          tick_d;

  always_comb
  begin
    tick_d = 1'b0;
    cnt_d  = cnt_q + 1'b1;
    if (cnt_q == CW'(DIV - 1))
    begin
      cnt_d  = '0;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;

endmodule
`default_nettype wire

// >>> tb/supply_model.sv
`default_nettype none
module supply_model
(
  // Clock and requested supply state
  input  wire logic       core_clk,
  input  wire logic [2:0] want,
  // Comparator levels, high while the supply is above its threshold
  output logic            analog_cmp,
  output logic            system_cmp,
  output logic            core_hi_cmp,
  output logic            core_lo_cmp
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    {analog_cmp, system_cmp, core_hi_cmp, core_lo_cmp} = 4'hF;
  end
  // Levels move just after an edge, so the design never sees a change on its sampling edge.
  always @(posedge core_clk)
  begin
    analog_cmp  <= #2 want == 3'h0;
    system_cmp  <= #2 want < 3'h2;
    core_hi_cmp <= #2 want < 3'h3;
    core_lo_cmp <= #2 want != 3'h5;
  end
endmodule
`default_nettype wire

// >>> tb/power_fault_reset_control_asserts.sv
`default_nettype none
module power_fault_reset_control_asserts
  import pwr_seq_pkg::*;
#(
  parameter int RESET_TIMER_TICKS = RESET_TICKS,
  parameter int DIV               = XTAL_DIV
)(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // Pins and events
  input  wire logic        test_pin,
  input  wire logic        debug_reset_n,
  input  wire logic        debug_enable_pin,
  input  wire logic        dog_overflow,
  // Register ports
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_rdata,
  input  wire logic [15:0] io_addr,
  input  wire logic        io_wr,
  input  wire logic [7:0]  io_wdata,
  // Observed outputs
  input  wire logic [2:0]  power_status_code,
  input  wire power_ctl_t  ctl,
  input  wire logic        battery_irq,
  input  wire logic        cpu_core_reset,
  input  wire logic        test_mux_reset,
  input  wire logic        rtc_reset,
  input  wire logic        wake,
  input  wire logic        dog_enable,
  input  wire logic        dog_restart,
  input  wire logic        low_battery_wake_flag,
  input  wire logic        dog_overflow_flag
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  a_status_read: assert property (sfr_rd && sfr_addr == SFR_POWER_STATUS |=>
    sfr_rdata == {5'h00, $past(power_status_code)}) else $error("status read mismatch");
  a_code_legal: assert property (power_status_code inside {3'h0, 3'h1, 3'h2, 3'h3, 3'h5})
    else $error("reserved status code");
  a_irq_on_switch: assert property ($rose(ctl.on_battery) |-> ##[0:2] battery_irq)
    else $error("no interrupt on battery switch");
  a_debug_core: assert property (!debug_reset_n [*6] |-> cpu_core_reset)
    else $error("debug reset not applied");
  a_dog_gate: assert property ($stable(debug_enable_pin) [*8] |-> dog_enable != debug_enable_pin)
    else $error("watchdog enable wrong");
  a_debug_restart: assert property (debug_enable_pin [*8] |-> dog_restart)
    else $error("watchdog not held in restart");
  a_kick_restart: assert property (io_wr && io_addr == IO_DOG_CTRL && io_wdata[DOG_KICK_BIT]
    |-> ##[1:2] dog_restart) else $error("kick did not restart watchdog");
  a_dog_flag_set: assert property (dog_overflow |=> dog_overflow_flag)
    else $error("overflow flag not set");
  a_soft_reset: assert property (io_wr && io_addr == IO_CLOCK_CTRL && io_wdata[SOFT_RESET_BIT]
    |-> ##[1:3] ctl.cpu_reset) else $error("soft reset missing");
  a_wake_clears: assert property ($fell(wake) |-> ##[0:2] !low_battery_wake_flag)
    else $error("flag kept after wake fell");
  a_test_gate: assert property (!test_pin [*8] |-> !test_mux_reset && !rtc_reset)
    else $error("test reset without test pin");
endmodule

bind power_fault_reset_control power_fault_reset_control_asserts #(
  .RESET_TIMER_TICKS(RESET_TIMER_TICKS), .DIV(DIV)
) u_power_fault_reset_control_asserts (
  .core_clk(core_clk), .nrst(nrst), .test_pin(test_pin), .debug_reset_n(debug_reset_n),
  .debug_enable_pin(debug_enable_pin), .dog_overflow(dog_overflow), .sfr_addr(sfr_addr),
  .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .io_addr(io_addr), .io_wr(io_wr), .io_wdata(io_wdata),
  .power_status_code(power_status_code), .ctl(ctl), .battery_irq(battery_irq),
  .cpu_core_reset(cpu_core_reset), .test_mux_reset(test_mux_reset), .rtc_reset(rtc_reset),
  .wake(wake), .dog_enable(dog_enable), .dog_restart(dog_restart),
  .low_battery_wake_flag(low_battery_wake_flag), .dog_overflow_flag(dog_overflow_flag)
);
`default_nettype wire

// >>> tb/power_fault_reset_control_test.sv
`default_nettype none
module power_fault_reset_control_test
  import pwr_seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int SIM_DIV   = 4;
  localparam int SIM_TICKS = 10;
  logic        core_clk, nrst, reset_pin, test_pin, debug_reset_n, debug_enable_pin;
  logic        dog_overflow, wake_event, sfr_rd, io_wr, io_rd;
  logic        ana_cmp, sys_cmp, hi_cmp, lo_cmp, analog_ok, system_ok, irq;
  logic        core_rst, test_mux_select_rst, rtc_rst, wake, dog_en, dog_rst, lowbat_flag, dog_flag;
  logic [7:0]  sfr_addr, sfr_rdata, io_wdata, io_rdata, rd;
  logic [15:0] io_addr, boot_addr, irqs;
  logic [2:0]  code, want;
  power_ctl_t  ctl;
  int          fails, checks_done, cycles;
  logic [2:0]  codes [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h0};

  supply_model u_supply_model (.core_clk(core_clk), .want(want), .analog_cmp(ana_cmp),
    .system_cmp(sys_cmp), .core_hi_cmp(hi_cmp), .core_lo_cmp(lo_cmp));
  power_fault_reset_control #(.RESET_TIMER_TICKS(SIM_TICKS), .DIV(SIM_DIV))
  u_power_fault_reset_control (.core_clk(core_clk), .nrst(nrst), .reset_pin(reset_pin),
    .test_pin(test_pin), .debug_reset_n(debug_reset_n), .debug_enable_pin(debug_enable_pin),
    .analog_supply_cmp(ana_cmp), .system_supply_cmp(sys_cmp), .core_supply_hi_cmp(hi_cmp),
    .core_supply_lo_cmp(lo_cmp), .dog_overflow(dog_overflow), .wake_event(wake_event),
    .sfr_addr(sfr_addr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .io_addr(io_addr),
    .io_wr(io_wr), .io_wdata(io_wdata), .io_rd(io_rd), .io_rdata(io_rdata),
    .power_status_code(code), .analog_supply_ok_flag(analog_ok), .system_supply_ok_flag(system_ok),
    .ctl(ctl), .battery_irq(irq), .cpu_core_reset(core_rst), .test_mux_reset(test_mux_select_rst),
    .rtc_reset(rtc_rst), .boot_addr(boot_addr), .wake(wake), .dog_enable(dog_en),
    .dog_restart(dog_rst), .low_battery_wake_flag(lowbat_flag), .dog_overflow_flag(dog_flag));

  initial
  begin
    core_clk = 1'h0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask

  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic sfr_read(input logic [7:0] a);
    sfr_addr = a;
    sfr_rd = 1'h1;
    step(1);
    sfr_rd = 1'h0;
    step(1);
    rd = sfr_rdata;
  endtask

  task automatic io_op(input logic w, input logic [15:0] a, input logic [7:0] d);
    io_addr = a;
    io_wdata = d;
    io_wr = w;
    io_rd = !w;
    step(1);
    io_wr = 1'h0;
    io_rd = 1'h0;
    step(1);
    rd = io_rdata;
  endtask

  task automatic pulse_overflow();
    dog_overflow = 1'h1;
    step(1);
    dog_overflow = 1'h0;
    step(2);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // The whole sequence needs about 520 cycles; the ceiling leaves ample slack.
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (irq === 1'h1)
      irqs <= irqs + 16'h0001;
    if (cycles == 6000)
    begin
      fails++;
      tally_and_finish();
    end
  end

  initial
  begin
    {reset_pin, test_pin, debug_enable_pin, dog_overflow, wake_event, sfr_rd, io_wr, io_rd} = 8'h00;
    {debug_reset_n, sfr_addr, io_addr, io_wdata, want, nrst} = {1'h1, 32'h0, 3'h0, 1'h0};
    {fails, checks_done, cycles, irqs} = '0;
    step(12);
    nrst = 1'h1;
    step(25);
    check_val(ctl.cpu_reset, 16'h1);
    step(50);
    check_val(ctl.cpu_reset, 16'h0);
    check_val(boot_addr, BOOT_ADDR);
    $display("test power_up done");
    foreach (codes[i])
    begin
      want = codes[i];
      step(12);
      sfr_read(SFR_POWER_STATUS);
      check_val(rd, {5'h00, codes[i]});
      check_val(analog_ok, codes[i] == 3'h0);
      check_val(system_ok, codes[i] < 3'h2);
      check_val(ctl.on_battery, codes[i] > 3'h1);
      check_val(ctl.flash_write_block, codes[i] == 3'h3);
      check_val(ctl.converter_clk_en, codes[i] < 3'h2);
    end
    check_val(irqs, 16'h1);
    sfr_read(8'hF8);
    check_val(rd, 8'h00);
    $display("test status_codes done");
    want = 3'h2;
    step(12);
    want = 3'h5;
    step(12);
    sfr_read(SFR_POWER_STATUS);
    check_val(rd, 8'h05);
    check_val(ctl.cpu_reset, 16'h0);
    step(LOWBAT_TICKS * SIM_DIV + 10);
    check_val(ctl.cpu_reset, 16'h1);
    check_val(wake, 16'h0);
    want = 3'h2;
    step(20);
    check_val(ctl.cpu_reset, 16'h0);
    io_op(1'h0, IO_WAKE_FLAGS, 8'h00);
    check_val(rd, 8'h04);
    $display("test low_battery done");
    pulse_overflow();
    io_op(1'h0, IO_WAKE_FLAGS, 8'h00);
    check_val(rd, 8'h14);
    io_op(1'h1, IO_DOG_CTRL, 8'h80);
    debug_enable_pin = 1'h1;
    step(10);
    check_val(dog_en, 16'h0);
    check_val(dog_rst, 16'h1);
    debug_enable_pin = 1'h0;
    step(10);
    check_val(dog_en, 16'h1);
    debug_reset_n = 1'h0;
    step(10);
    check_val(core_rst, 16'h1);
    check_val(ctl.cpu_reset, 16'h0);
    debug_reset_n = 1'h1;
    step(10);
    check_val(core_rst, 16'h0);
    $display("test watchdog_debug done");
    {reset_pin, test_pin} = 2'h3;
    step(100);
    check_val({test_mux_select_rst, rtc_rst}, 16'h3);
    check_val(ctl.cpu_reset, 16'h1);
    check_val(ctl.chip_reset, 16'h1);
    {reset_pin, test_pin} = 2'h0;
    step(25);
    check_val(ctl.cpu_reset, 16'h0);
    check_val(ctl.battery_run_mode, 16'h1);
    io_op(1'h0, IO_WAKE_FLAGS, 8'h00);
    check_val(rd & 8'h10, 8'h00);
    $display("test pin_reset done");
    pulse_overflow();
    io_op(1'h1, IO_MODE_CTRL, 8'hC0);
    step(2);
    check_val({wake, dog_flag, lowbat_flag}, 16'h0);
    want = 3'h5;
    step(12);
    wake_event = 1'h1;
    step(1);
    wake_event = 1'h0;
    step(20);
    check_val({ctl.cpu_reset, wake}, 16'h2);
    want = 3'h2;
    step(30);
    check_val({ctl.cpu_reset, wake}, 16'h1);
    $display("test dormant_wake done");
    io_op(1'h1, IO_CLOCK_CTRL, 8'h08);
    check_val(ctl.cpu_reset, 16'h1);
    step(SOFT_RESET_TICKS * SIM_DIV + 10);
    check_val(ctl.cpu_reset, 16'h0);
    $display("test soft_reset done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
